// *** core/dlsi_pkg.sv ***
// constants and types shared by the lvds sample input block
package dlsi_pkg;
  localparam int SAMPLE_W   = 12;
  localparam int BUS_N      = 4;
  localparam int MARK_BIT   = 2 * SAMPLE_W;
  localparam int WORD_W     = 2 * SAMPLE_W + 1;
  localparam int RISE_LSB   = 0;
  localparam int FALL_LSB   = SAMPLE_W;
  localparam int FIFO_DEPTH = 8;
  localparam int MAX_LANES  = BUS_N * SAMPLE_W;
  localparam int LANE_MAX_MBPS = 1600;
  // strobe grid: four forwarded clocks, eight samples per bus
  localparam int STROBE_GRID_CLKS   = 4;
  localparam int STROBE_GRID_SAMPLES = 2 * STROBE_GRID_CLKS;
  localparam int SLOT_W     = $clog2(STROBE_GRID_CLKS);
  // lane configuration codes
  localparam logic [1:0] CFG_DUAL_ONE_BUS  = 2'h0;
  localparam logic [1:0] CFG_DUAL_TWO_BUS  = 2'h1;
  localparam logic [1:0] CFG_SINGLE_FOUR   = 2'h2;
  localparam logic [1:0] CFG_RESET         = 2'h0;
  // buses in use per configuration, bit 0 is bus A
  localparam logic [3:0] MASK_DUAL_ONE_BUS = 4'h5;
  localparam logic [3:0] MASK_FOUR_BUS     = 4'hF;
  // rate figures in MHz
  localparam logic [15:0] RATE_1600 = 16'h0640;
  localparam logic [15:0] RATE_3200 = 16'h0C80;
  localparam logic [15:0] RATE_6400 = 16'h1900;
  typedef enum logic [1:0] {ALIGN_ARM, ALIGN_HUNT, ALIGN_RUN} dlsi_align_t;
endpackage

// *** core/dlsi_sample_input.sv ***
// lvds sample input: ddr capture per bus, crossing fifos, strobe alignment, sample ordering
// Behaviour
// - up to four 12-bit buses, 48 lanes, each lane at most 1.6 Gbps.
// - every used bus brings its own forwarded ddr clock from the sender.
// - strobes plus the system reference give deterministic input-to-output latency.
// - buses feeding one channel are aligned to each other using their strobes.
// - a channel's samples spread over its buses in alphabetical order, earliest first.
// - two buses per channel: channel A takes A then B, B takes C then D.
// - configuration 1 dual four buses, 0 dual two buses, 2 single four buses.
// - clock doubling in dual mode doubles sample clock: 6400 or 3200 MHz.
// - channel rates 3200 dual-four, 1600 dual-two, 6400 single at 1600 Mbps.
// - dual four buses: channel A uses buses A, B; channel B uses C, D.
// - aligned clocks with two buses per channel make B and D early by one.
// - one bus per channel: channel A from bus A, channel B from bus C.
// - no strict skew limit between buses while crossing fifos keep pointer margin.
// - single channel is fed from all four buses, 48 lanes, each with own clock.
// - aligned clocks in single mode make the fourth bank early by three.
// - a received strobe restarts that bus's slot count in the strobe grid; its fifo pointers are not reset.
`timescale 1ns/10ps

module dlsi_cdc_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input  wire logic             wr_clk,   // write side clock
  input  wire logic             wr_rst,   // write side sync reset
  input  wire logic             wr_valid, // word offered
  output logic                  wr_ready, // room for a word
  input  wire logic [WIDTH-1:0] wr_data,  // word written
  input  wire logic             rd_clk,   // read side clock
  input  wire logic             rd_rst,   // read side sync reset
  output logic                  rd_valid, // head word present
  input  wire logic             rd_ready, // head word taken
  output logic [WIDTH-1:0]      rd_data   // head word
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_q, wbin_d, wgray_q, wgray_d, rg_s1, rg_s2;
  logic [AW:0]      rbin_q, rbin_d, rgray_q, rgray_d, wg_s1, wg_s2;
  logic             push, pop;

  // full compares against the read pointer two flops late, so it is pessimistic, never wrong
  assign wr_ready = (wgray_q != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
  assign push     = wr_valid & wr_ready;
  assign rd_valid = (rgray_q != wg_s2);
  assign pop      = rd_valid & rd_ready;
  assign rd_data  = mem[rbin_q[AW-1:0]];

  always_comb begin
    wbin_d  = wbin_q + {{AW{1'b0}}, push};
    wgray_d = to_gray(wbin_d);
    rbin_d  = rbin_q + {{AW{1'b0}}, pop};
    rgray_d = to_gray(rbin_d);
  end

  always_ff @(posedge wr_clk) begin
    if (wr_rst) begin
      wbin_q  <= '0;
      wgray_q <= '0;
      rg_s1   <= '0;
      rg_s2   <= '0;
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= wgray_d;
      rg_s1   <= rgray_q;
      rg_s2   <= rg_s1;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rbin_q  <= '0;
      rgray_q <= '0;
      wg_s1   <= '0;
      wg_s2   <= '0;
    end else begin
      rbin_q  <= rbin_d;
      rgray_q <= rgray_d;
      wg_s1   <= wgray_q;
      wg_s2   <= wg_s1;
    end
  end
endmodule

module dlsi_sample_input (
  input  wire logic        CLK,                   // converter side clock
  input  wire logic        RESET,                 // sync reset, active high
  input  wire logic        BUS_A_FWD_CLOCK,       // bus A forwarded ddr clock
  input  wire logic [11:0] BUS_A_DATA,            // bus A lanes
  input  wire logic        BUS_A_STROBE,          // bus A align strobe
  input  wire logic        BUS_B_FWD_CLOCK,       // bus B forwarded ddr clock
  input  wire logic [11:0] BUS_B_DATA,            // bus B lanes
  input  wire logic        BUS_B_STROBE,          // bus B align strobe
  input  wire logic        BUS_C_FWD_CLOCK,       // bus C forwarded ddr clock
  input  wire logic [11:0] BUS_C_DATA,            // bus C lanes
  input  wire logic        BUS_C_STROBE,          // bus C align strobe
  input  wire logic        BUS_D_FWD_CLOCK,       // bus D forwarded ddr clock
  input  wire logic [11:0] BUS_D_DATA,            // bus D lanes
  input  wire logic        BUS_D_STROBE,          // bus D align strobe
  input  wire logic [1:0]  LANE_CONFIG,           // lane configuration pin
  input  wire logic        CLOCK_DOUBLING_SELECT, // 2x sample clock pin
  input  wire logic        SYSREF,                // system reference pin
  input  wire logic        OUT_READY,             // consumer takes samples
  output logic             OUT_VALID,             // sample group valid
  output logic [95:0]      CHAN_A_SAMPLES,        // channel A, earliest in low bits
  output logic [47:0]      CHAN_B_SAMPLES,        // channel B, earliest in low bits
  output logic [1:0]       ACTIVE_CONFIG,         // configuration in use
  output logic             DOUBLE_RATE_RF_OUTPUT, // 2x rf output active
  output logic [15:0]      MAX_SAMPLE_CLK_MHZ,    // sample clock ceiling
  output logic [15:0]      MAX_CHAN_RATE_MHZ,     // channel rate ceiling
  output logic             ALIGNED,               // buses aligned, running
  output logic             ALIGN_LOST,            // pulse: strobes disagreed
  output logic             FIFO_OVERFLOW,         // sticky: a word was dropped
  output logic             STROBE_OFF_GRID        // sticky: strobe off 4-clock grid
);
  localparam int W  = dlsi_pkg::WORD_W;
  localparam int SW = dlsi_pkg::SAMPLE_W;
  localparam int N  = dlsi_pkg::BUS_N;

  function automatic logic [3:0] bus_mask(input logic [1:0] cfg);
    case (cfg)
      dlsi_pkg::CFG_DUAL_ONE_BUS: bus_mask = dlsi_pkg::MASK_DUAL_ONE_BUS;
      dlsi_pkg::CFG_DUAL_TWO_BUS: bus_mask = dlsi_pkg::MASK_FOUR_BUS;
      dlsi_pkg::CFG_SINGLE_FOUR:  bus_mask = dlsi_pkg::MASK_FOUR_BUS;
      default:                    bus_mask = 4'h0;
    endcase
  endfunction

  function automatic logic [15:0] chan_rate(input logic [1:0] cfg);
    case (cfg)
      dlsi_pkg::CFG_DUAL_ONE_BUS: chan_rate = dlsi_pkg::RATE_1600;
      dlsi_pkg::CFG_DUAL_TWO_BUS: chan_rate = dlsi_pkg::RATE_3200;
      dlsi_pkg::CFG_SINGLE_FOUR:  chan_rate = dlsi_pkg::RATE_6400;
      default:                    chan_rate = 16'h0000;
    endcase
  endfunction

  logic [3:0]    fwd_clk;
  logic [SW-1:0] bus_data [N];
  logic [3:0]    bus_stb;
  logic [W-1:0]  head [N];
  logic [3:0]    head_valid, mark, pop, ovf_w, grid_w;

  assign fwd_clk = {BUS_D_FWD_CLOCK, BUS_C_FWD_CLOCK, BUS_B_FWD_CLOCK, BUS_A_FWD_CLOCK};
  assign bus_stb = {BUS_D_STROBE, BUS_C_STROBE, BUS_B_STROBE, BUS_A_STROBE};
  assign bus_data[0] = BUS_A_DATA;
  assign bus_data[1] = BUS_B_DATA;
  assign bus_data[2] = BUS_C_DATA;
  assign bus_data[3] = BUS_D_DATA;

  // link side: one capture stage and crossing fifo per bus, each on its own forwarded clock
  for (genvar i = 0; i < N; i++) begin : g_bus
    logic                              lrst_s1, lrst_s2;
    logic [SW-1:0]                     rise_q, rise_d, fall_q;
    logic                              stb_q, stb_d, pair_q, pair_d, seen_q, seen_d;
    logic                              grid_q, grid_d, ovf_q, ovf_d, wr_ready;
    logic [dlsi_pkg::SLOT_W-1:0]       slot_q, slot_d;

    always_ff @(posedge fwd_clk[i]) begin
      lrst_s1 <= RESET;
      lrst_s2 <= lrst_s1;
    end

    always_ff @(negedge fwd_clk[i]) begin
      fall_q <= bus_data[i];
    end

    always_comb begin
      rise_d = bus_data[i];
      stb_d  = bus_stb[i];
      pair_d = 1'b1;
      // write position within the strobe frame restarts on each strobe
      slot_d = stb_q ? {{(dlsi_pkg::SLOT_W-1){1'b0}}, 1'b1}
                     : slot_q + {{(dlsi_pkg::SLOT_W-1){1'b0}}, 1'b1};
      seen_d = seen_q | stb_q;
      grid_d = grid_q | (stb_q & seen_q & (slot_q != '0));
      ovf_d  = ovf_q | (pair_q & ~wr_ready);
    end

    always_ff @(posedge fwd_clk[i]) begin
      if (lrst_s2) begin
        rise_q <= '0;
        stb_q  <= 1'b0;
        pair_q <= 1'b0;
        slot_q <= '0;
        seen_q <= 1'b0;
        grid_q <= 1'b0;
        ovf_q  <= 1'b0;
      end else begin
        rise_q <= rise_d;
        stb_q  <= stb_d;
        pair_q <= pair_d;
        slot_q <= slot_d;
        seen_q <= seen_d;
        grid_q <= grid_d;
        ovf_q  <= ovf_d;
      end
    end

    assign ovf_w[i]  = ovf_q;
    assign grid_w[i] = grid_q;
    assign mark[i]   = head[i][dlsi_pkg::MARK_BIT];

    // word = {strobe mark, falling sample, rising sample}; the rising one is earlier
    dlsi_cdc_fifo #(
      .WIDTH (W),
      .DEPTH (dlsi_pkg::FIFO_DEPTH)
    ) u_fifo (
      .wr_clk   (fwd_clk[i]),
      .wr_rst   (lrst_s2),
      .wr_valid (pair_q),
      .wr_ready (wr_ready),
      .wr_data  ({stb_q, fall_q, rise_q}),
      .rd_clk   (CLK),
      .rd_rst   (RESET),
      .rd_valid (head_valid[i]),
      .rd_ready (pop[i]),
      .rd_data  (head[i])
    );

    link_slot_a: assert property (@(posedge fwd_clk[i]) disable iff (lrst_s2)
      stb_q |=> slot_q == {{(dlsi_pkg::SLOT_W-1){1'b0}}, 1'b1})
      else $error("write position not restarted by strobe");
  end

  // converter side
  logic [1:0]          cfg_s1, cfg_s2, cfg_q;
  logic                dbl_s1, dbl_s2, dbl_q, ref_s1, ref_s2, ref_s3;
  logic [3:0]          ovf_s1, ovf_s2, grid_s1, grid_s2;
  dlsi_pkg::dlsi_align_t state_q, state_d;
  logic                out_valid_d, load, lost, ovf_d, offgrid_d;
  logic [95:0]         samp_a_d;
  logic [47:0]         samp_b_d;
  logic [15:0]         chan_rate_d, clk_rate_d;
  logic                rf_d;
  logic [3:0]          mask;
  logic                sysref_edge, cfg_change, all_valid, all_mark, any_mark, out_free;

  assign mask        = bus_mask(cfg_q);
  assign sysref_edge = ref_s2 & ~ref_s3;
  assign cfg_change  = (cfg_s2 != cfg_q);
  assign all_valid   = &(head_valid | ~mask);
  assign all_mark    = (mask != 4'h0) && &((head_valid & mark) | ~mask);
  assign any_mark    = |(head_valid & mark & mask);
  assign out_free    = ~OUT_VALID | OUT_READY;

  always_comb begin
    state_d = state_q;
    pop     = 4'h0;
    load    = 1'b0;
    lost    = 1'b0;
    if (cfg_change) begin
      state_d = dlsi_pkg::ALIGN_ARM;
    end else begin
      case (state_q)
        dlsi_pkg::ALIGN_ARM: begin
          // flush until the reference fixes the start point
          pop = head_valid & mask;
          if (sysref_edge && mask != 4'h0) begin
            state_d = dlsi_pkg::ALIGN_HUNT;
          end
        end
        dlsi_pkg::ALIGN_HUNT: begin
          if (all_mark) begin
            state_d = dlsi_pkg::ALIGN_RUN;
          end else begin
            pop = head_valid & mask & ~mark;
          end
        end
        dlsi_pkg::ALIGN_RUN: begin
          // early buses simply wait in their fifo; that is the extra latency of aligned clocks
          if (all_valid && out_free) begin
            if (any_mark && !all_mark) begin
              state_d = dlsi_pkg::ALIGN_HUNT;
              lost    = 1'b1;
            end else begin
              pop  = mask;
              load = 1'b1;
            end
          end
        end
        default: state_d = dlsi_pkg::ALIGN_ARM;
      endcase
    end
  end

  always_comb begin
    samp_a_d = CHAN_A_SAMPLES;
    samp_b_d = CHAN_B_SAMPLES;
    if (load) begin
      samp_a_d = '0;
      samp_b_d = '0;
      case (cfg_q)
        dlsi_pkg::CFG_DUAL_ONE_BUS: begin
          samp_a_d[2*SW-1:0] = head[0][2*SW-1:0];
          samp_b_d[2*SW-1:0] = head[2][2*SW-1:0];
        end
        dlsi_pkg::CFG_DUAL_TWO_BUS: begin
          samp_a_d[4*SW-1:0] = {head[1][dlsi_pkg::FALL_LSB +: SW],
                                head[0][dlsi_pkg::FALL_LSB +: SW],
                                head[1][dlsi_pkg::RISE_LSB +: SW],
                                head[0][dlsi_pkg::RISE_LSB +: SW]};
          samp_b_d[4*SW-1:0] = {head[3][dlsi_pkg::FALL_LSB +: SW],
                                head[2][dlsi_pkg::FALL_LSB +: SW],
                                head[3][dlsi_pkg::RISE_LSB +: SW],
                                head[2][dlsi_pkg::RISE_LSB +: SW]};
        end
        dlsi_pkg::CFG_SINGLE_FOUR: begin
          samp_a_d = {head[3][dlsi_pkg::FALL_LSB +: SW], head[2][dlsi_pkg::FALL_LSB +: SW],
                      head[1][dlsi_pkg::FALL_LSB +: SW], head[0][dlsi_pkg::FALL_LSB +: SW],
                      head[3][dlsi_pkg::RISE_LSB +: SW], head[2][dlsi_pkg::RISE_LSB +: SW],
                      head[1][dlsi_pkg::RISE_LSB +: SW], head[0][dlsi_pkg::RISE_LSB +: SW]};
        end
        default: ;
      endcase
    end
    out_valid_d = load | (OUT_VALID & ~OUT_READY);
    chan_rate_d = chan_rate(cfg_q);
    rf_d        = dbl_q & (cfg_q != dlsi_pkg::CFG_SINGLE_FOUR) & (mask != 4'h0);
    clk_rate_d  = rf_d ? {chan_rate_d[14:0], 1'b0} : chan_rate_d;
    ovf_d       = FIFO_OVERFLOW | (|ovf_s2);
    offgrid_d   = STROBE_OFF_GRID | (|grid_s2);
  end

  always_ff @(posedge CLK) begin
    cfg_s1  <= LANE_CONFIG;
    cfg_s2  <= cfg_s1;
    dbl_s1  <= CLOCK_DOUBLING_SELECT;
    dbl_s2  <= dbl_s1;
    ref_s1  <= SYSREF;
    ref_s2  <= ref_s1;
    ovf_s1  <= ovf_w;
    ovf_s2  <= ovf_s1;
    grid_s1 <= grid_w;
    grid_s2 <= grid_s1;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg_q                 <= dlsi_pkg::CFG_RESET;
      dbl_q                 <= 1'b0;
      ref_s3                <= 1'b0;
      state_q               <= dlsi_pkg::ALIGN_ARM;
      OUT_VALID             <= 1'b0;
      CHAN_A_SAMPLES        <= '0;
      CHAN_B_SAMPLES        <= '0;
      ACTIVE_CONFIG         <= dlsi_pkg::CFG_RESET;
      DOUBLE_RATE_RF_OUTPUT <= 1'b0;
      MAX_SAMPLE_CLK_MHZ    <= '0;
      MAX_CHAN_RATE_MHZ     <= '0;
      ALIGNED               <= 1'b0;
      ALIGN_LOST            <= 1'b0;
      FIFO_OVERFLOW         <= 1'b0;
      STROBE_OFF_GRID       <= 1'b0;
    end else begin
      cfg_q                 <= cfg_s2;
      dbl_q                 <= dbl_s2;
      ref_s3                <= ref_s2;
      state_q               <= state_d;
      OUT_VALID             <= out_valid_d;
      CHAN_A_SAMPLES        <= samp_a_d;
      CHAN_B_SAMPLES        <= samp_b_d;
      ACTIVE_CONFIG         <= cfg_q;
      DOUBLE_RATE_RF_OUTPUT <= rf_d;
      MAX_SAMPLE_CLK_MHZ    <= clk_rate_d;
      MAX_CHAN_RATE_MHZ     <= chan_rate_d;
      ALIGNED               <= (state_d == dlsi_pkg::ALIGN_RUN);
      ALIGN_LOST            <= lost;
      FIFO_OVERFLOW         <= ovf_d;
      STROBE_OFF_GRID       <= offgrid_d;
    end
  end

  joint_pop_a: assert property (@(posedge CLK) disable iff (RESET)
    (state_q == dlsi_pkg::ALIGN_RUN && (pop & mask) != 4'h0) |-> (pop == mask))
    else $error("aligned buses not taken together");

  first_sample_a: assert property (@(posedge CLK) disable iff (RESET)
    load |=> CHAN_A_SAMPLES[SW-1:0] == $past(head[0][SW-1:0]) && OUT_VALID)
    else $error("channel A first sample not from bus A");

  second_from_b_a: assert property (@(posedge CLK) disable iff (RESET)
    (load && cfg_q == dlsi_pkg::CFG_DUAL_TWO_BUS)
      |=> CHAN_A_SAMPLES[2*SW-1:SW] == $past(head[1][SW-1:0]))
    else $error("channel A second sample not from bus B");

  chan_b_cd_a: assert property (@(posedge CLK) disable iff (RESET)
    (load && cfg_q == dlsi_pkg::CFG_DUAL_TWO_BUS)
      |=> CHAN_B_SAMPLES[2*SW-1:SW] == $past(head[3][SW-1:0]))
    else $error("channel B second sample not from bus D");

  one_bus_map_a: assert property (@(posedge CLK) disable iff (RESET)
    (load && cfg_q == dlsi_pkg::CFG_DUAL_ONE_BUS)
      |=> CHAN_B_SAMPLES[SW-1:0] == $past(head[2][SW-1:0]) && CHAN_B_SAMPLES[47:2*SW] == '0)
    else $error("one-bus channel B not from bus C");

  unused_bus_a: assert property (@(posedge CLK) disable iff (RESET)
    (pop & ~bus_mask(cfg_q)) == 4'h0)
    else $error("bus outside configuration drained");

  single_all_a: assert property (@(posedge CLK) disable iff (RESET)
    (load && cfg_q == dlsi_pkg::CFG_SINGLE_FOUR) |-> pop == dlsi_pkg::MASK_FOUR_BUS)
    else $error("single channel load without four buses");

  doubled_clk_a: assert property (@(posedge CLK) disable iff (RESET)
    (dbl_q && cfg_q == dlsi_pkg::CFG_DUAL_TWO_BUS) |=> MAX_SAMPLE_CLK_MHZ == dlsi_pkg::RATE_6400)
    else $error("doubled sample clock ceiling wrong");

  single_rate_a: assert property (@(posedge CLK) disable iff (RESET)
    (cfg_q == dlsi_pkg::CFG_SINGLE_FOUR) |=> MAX_CHAN_RATE_MHZ == dlsi_pkg::RATE_6400
      && !DOUBLE_RATE_RF_OUTPUT)
    else $error("single channel rate ceiling wrong");

  ref_start_a: assert property (@(posedge CLK) disable iff (RESET)
    ($past(state_q) == dlsi_pkg::ALIGN_ARM && state_q == dlsi_pkg::ALIGN_HUNT)
      |-> $past(sysref_edge))
    else $error("alignment started without reference edge");

  run_cover_c: cover property (@(posedge CLK) disable iff (RESET)
    state_q == dlsi_pkg::ALIGN_HUNT ##1 state_q == dlsi_pkg::ALIGN_RUN ##[1:40] OUT_VALID);
  lost_cover_c: cover property (@(posedge CLK) disable iff (RESET) ALIGN_LOST);
  single_cover_c: cover property (@(posedge CLK) disable iff (RESET)
    load && cfg_q == dlsi_pkg::CFG_SINGLE_FOUR);
  stall_cover_c: cover property (@(posedge CLK) disable iff (RESET)
    OUT_VALID && !OUT_READY ##1 OUT_VALID && OUT_READY);
endmodule

// *** verif/dlsi_link_model.sv ***
// behavioural sender driving the four lvds sample buses
`timescale 1ns/10ps
module dlsi_link_model (
  input  wire logic        en,       // run the forwarded clock
  input  wire logic        off_grid, // deliberate fault: extra mid-grid strobe
  input  wire logic        drop_a,   // deliberate fault: bus A strobe withheld
  output logic             fclk,     // forwarded ddr clock, one copy per bus
  output logic [3:0][11:0] data,     // lanes, bus A at index 0
  output logic [3:0]       strobe    // align strobes, bus A at bit 0
);
  logic [8:0] cnt;
  // aligned copies are the worst case for skew, the receiver fifos absorb it
  initial begin
    fclk = 1'b0;
    cnt = '0;
    data = '0;
    strobe = '0;
    #7;
    forever begin
      #24;
      fclk = en ? ~fclk : 1'b0;
    end
  end
  // words move a quarter period after each edge so each capture edge sits mid-eye
  always @(posedge fclk) begin
    #12;
    strobe = '0;
    for (int b = 0; b < 4; b++) data[b] = {b[1:0], cnt, 1'b1};
    cnt = cnt + 9'h001;
  end
  always @(negedge fclk) begin
    #12;
    for (int b = 0; b < 4; b++) data[b] = {b[1:0], cnt, 1'b0};
    strobe = {4{cnt[1:0] == 2'h0 || (off_grid && cnt[1:0] == 2'h2)}} & {3'h7, ~drop_a};
  end
endmodule

// *** verif/dlsi_sample_input_tb_top.sv ***
// testbench: rates, stream ordering per configuration, back-pressure and fault flags
`timescale 1ns/10ps
module dlsi_sample_input_tb_top;
  logic             clk, rst, sysref, out_ready, dbl, en, off_grid, fclk, drop_a, lost_seen;
  logic [1:0]       cfg, act_cfg;
  logic [3:0][11:0] data;
  logic [3:0]       strobe;
  logic             out_valid, aligned, lost, fifo_ovf, grid_err, rf_out;
  logic [95:0]      chan_a;
  logic [47:0]      chan_b;
  logic [15:0]      max_clk, max_rate;
  int               fails, checked;
  dlsi_link_model dlsi_link_model_inst (.en(en), .off_grid(off_grid), .drop_a(drop_a), .fclk(fclk),
    .data(data), .strobe(strobe));
  dlsi_sample_input dlsi_sample_input_inst (.CLK(clk), .RESET(rst),
    .BUS_A_FWD_CLOCK(fclk), .BUS_A_DATA(data[0]), .BUS_A_STROBE(strobe[0]),
    .BUS_B_FWD_CLOCK(fclk), .BUS_B_DATA(data[1]), .BUS_B_STROBE(strobe[1]),
    .BUS_C_FWD_CLOCK(fclk), .BUS_C_DATA(data[2]), .BUS_C_STROBE(strobe[2]),
    .BUS_D_FWD_CLOCK(fclk), .BUS_D_DATA(data[3]), .BUS_D_STROBE(strobe[3]),
    .LANE_CONFIG(cfg), .CLOCK_DOUBLING_SELECT(dbl), .SYSREF(sysref), .OUT_READY(out_ready),
    .OUT_VALID(out_valid), .CHAN_A_SAMPLES(chan_a), .CHAN_B_SAMPLES(chan_b),
    .ACTIVE_CONFIG(act_cfg), .DOUBLE_RATE_RF_OUTPUT(rf_out), .MAX_SAMPLE_CLK_MHZ(max_clk),
    .MAX_CHAN_RATE_MHZ(max_rate), .ALIGNED(aligned), .ALIGN_LOST(lost),
    .FIFO_OVERFLOW(fifo_ovf), .STROBE_OFF_GRID(grid_err));
  always #25 clk = ~clk;
  // the loss flag is a one-cycle pulse, so it is caught here while it stands
  always @(negedge clk) if (lost === 1'b1) lost_seen = 1'b1;
  task automatic report_and_stop;
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bad(input string m);
    fails++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // reset also covers three or more forwarded edges, the link side syncs it
  task automatic do_reset(input logic [1:0] c);
    rst = 1'b1;
    cfg = c;
    cyc(4);
    rst = 1'b0;
    cyc(8);
  endtask
  task automatic wait_valid;
    int i;
    for (i = 0; i < 400 && out_valid !== 1'b1; i++) cyc(1);
    if (i == 400) begin
      bad("no sample group");
      report_and_stop();
    end
  endtask
  task automatic scen_rates;
    logic [15:0] r;
    for (int c = 0; c < 4; c++) for (int d = 0; d < 2; d++) begin
      dbl = d[0];
      do_reset(c[1:0]);
      r = c == 0 ? dlsi_pkg::RATE_1600 : c == 1 ? dlsi_pkg::RATE_3200 :
          c == 2 ? dlsi_pkg::RATE_6400 : 16'h0000;
      checked++;
      if (act_cfg !== c[1:0] || max_rate !== r) bad("config or channel rate");
      checked++;
      if (rf_out !== (d == 1 && c < 2) || max_clk !== ((d == 1 && c < 2) ? r << 1 : r)) bad("doubling");
    end
  endtask
  task automatic scen_stream(input logic [1:0] c);
    logic [8:0]  c0;
    logic [11:0] e, a;
    int          nb, s;
    do_reset(c);
    cyc(20);
    checked++;
    if (out_valid !== 1'b0) bad("group before reference");
    sysref = 1'b1;
    cyc(3);
    sysref = 1'b0;
    wait_valid();
    c0 = chan_a[9:1];
    checked++;
    if (c0[1:0] !== 2'h0 || aligned !== 1'b1 || grid_err !== 1'b0) bad("first group off strobe");
    nb = c == 2'h2 ? 4 : c == 2'h1 ? 2 : 1;
    for (int g = 0; g < 2; g++) begin
      for (int k = 0; k < 12; k++) begin
        s = k < 8 ? k : k - 8;
        e = {k < 8 ? 2'(s % nb) : 2'(2 + s % nb), c0 + g[8:0], s / nb == 1 || s / nb == 3};
        if (s >= 2 * nb || (k >= 8 && c == 2'h2)) e = '0;
        a = k < 8 ? chan_a[12 * s +: 12] : chan_b[12 * s +: 12];
        checked++;
        if (a !== e) bad("sample order");
      end
      if (g == 0) begin
        out_ready = 1'b1;
        cyc(1);
        out_ready = 1'b0;
        wait_valid();
      end
    end
  endtask
  // consumer stalls while the sender runs on, then the sender stops and all drains
  task automatic scen_stall;
    logic [95:0] held;
    held = chan_a;
    cyc(60);
    checked++;
    if (out_valid !== 1'b1 || chan_a !== held) bad("group not held");
    checked++;
    if (fifo_ovf !== 1'b1) bad("full fifo not flagged");
    en = 1'b0;
    out_ready = 1'b1;
    cyc(30);
    checked++;
    if (out_valid !== 1'b0) bad("fifo not drained");
    out_ready = 1'b0;
    en = 1'b1;
  endtask
  task automatic scen_off_grid;
    do_reset(2'h1);
    off_grid = 1'b1;
    cyc(20);
    off_grid = 1'b0;
    checked++;
    if (grid_err !== 1'b1) bad("off-grid strobe not flagged");
  endtask
  // bus A loses its strobes while the others keep them: alignment must be dropped
  task automatic scen_lost;
    do_reset(2'h2);
    sysref = 1'b1;
    cyc(3);
    sysref = 1'b0;
    out_ready = 1'b1;
    wait_valid();
    lost_seen = 1'b0;
    cyc(20);
    checked++;
    if (lost_seen !== 1'b0) bad("loss flagged while strobes agree");
    drop_a = 1'b1;
    cyc(20);
    drop_a = 1'b0;
    out_ready = 1'b0;
    checked++;
    if (lost_seen !== 1'b1) bad("strobe disagreement not flagged");
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    sysref = 1'b0;
    out_ready = 1'b0;
    dbl = 1'b0;
    cfg = 2'h0;
    en = 1'b1;
    off_grid = 1'b0;
    drop_a = 1'b0;
    lost_seen = 1'b0;
    fails = 0;
    checked = 0;
    scen_rates();
    scen_stream(2'h0);
    scen_stream(2'h2);
    scen_stream(2'h1);
    scen_stall();
    scen_off_grid();
    scen_lost();
    report_and_stop();
  end
endmodule
